// File: include/fsp_pkg.sv
package fsp_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int SECT_W = 4;
  localparam int CLK_PERIOD_NS = 20;
  localparam int PROT_PULSE_NS = 10000;
  localparam int UNPROT_PULSE_NS = 12000000;
  localparam int SETUP_NS = 100;
  localparam int PROT_PULSE_CYC = PROT_PULSE_NS / CLK_PERIOD_NS;
  localparam int UNPROT_PULSE_CYC = UNPROT_PULSE_NS / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_NS = 100;
  localparam int READ_CYC = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_ZERO_POS = 0;
  localparam int ADDR_ONE_POS = 1;
  localparam int ADDR_SIX_POS = 6;
  localparam int SECT_POS = 14;
  localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [DATA_W-1:0] CMD_ID_READ = 8'h90;
  localparam logic [DATA_W-1:0] CMD_RESET = 8'hF0;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 18'h00555;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 18'h002AA;

  typedef enum logic [2:0] {
    OP_PROTECT,
    OP_UNPROTECT,
    OP_VERIFY,
    OP_SYS_STATUS
  } fsp_op_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic oe_hv;
    logic address_bit_nine_hv;
    logic [ADDR_W-1:0] addr;
  } fsp_pins_t;
endpackage

// File: design/fsp_pulse.sv
`timescale 1ns/1ps
// Counts a fixed number of cycles after start, pulses done at the end.
module fsp_pulse #(
  parameter int CNT_W = 20
) (
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Sync reset, high
  input wire logic start_in, // Load count
  input wire logic [CNT_W-1:0] len_in, // Cycles to run
  output logic busy_out, // Counting
  output logic done_out // Last cycle
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (start_in) begin
      cnt_d = len_in;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q <= CNT_W'(1)) begin
        busy_d = 1'b0;
      end else begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign busy_out = busy_q;
  // Must not look at start_in: callers restart from done in the same cycle
  assign done_out = busy_q && (cnt_q <= CNT_W'(1));
endmodule

// File: design/fsp_host.sv
`timescale 1ns/1ps
// Drives the flash pins to protect a sector, unprotect the chip,
// verify protection with raised voltage, or read status in system.
module fsp_host
  import fsp_pkg::*;
#(
  parameter int PROT_CYC = PROT_PULSE_CYC,
  parameter int UNPROT_CYC = UNPROT_PULSE_CYC
) (
  input wire logic MCLK_IN, // 50 MHz clock
  input wire logic RESET_IN, // Sync reset, high
  input wire logic REQ_VALID_IN, // Request strobe
  output logic REQ_READY_OUT, // Idle, may take request
  input wire fsp_pkg::fsp_op_t REQ_OP_IN, // Operation
  input wire logic [fsp_pkg::SECT_W-1:0] REQ_SECTOR_IN, // Sector
  output logic DONE_OUT, // One-cycle completion pulse
  output logic PROTECTED_OUT, // Last status result
  output logic [fsp_pkg::DATA_W-1:0] STATUS_DATA_OUT, // Raw data read
  output fsp_pkg::fsp_pins_t PINS_OUT, // Flash control/address
  output logic [fsp_pkg::DATA_W-1:0] DQ_OUT, // Data to flash
  output logic DQ_OE_N_OUT, // Low while host drives data
  input wire logic [fsp_pkg::DATA_W-1:0] DQ_IN // Data from flash
);
  import fsp_pkg::*;

  localparam int CNT_W = 20;

  typedef enum {
    S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_RDSET, S_RDWAIT,
    S_CMD, S_CMDW, S_CMDGAP, S_RST, S_RSTW, S_DONE
  } fsp_state_t;

  fsp_state_t st_q, st_d;
  fsp_op_t op_q, op_d;
  logic [SECT_W-1:0] sect_q, sect_d;
  fsp_pins_t pins_q, pins_d;
  logic [DATA_W-1:0] dq_q, dq_d, stat_q, stat_d;
  logic dq_oe_n_q, dq_oe_n_d, prot_q, prot_d;
  logic [1:0] cmd_q, cmd_d;
  logic t_start;
  logic [CNT_W-1:0] t_len;
  logic t_busy, t_done;

  function automatic logic [ADDR_W-1:0] sect_addr(
    input logic [SECT_W-1:0] s, input logic a1, input logic a6);
    logic [ADDR_W-1:0] a;
    a = '0;
    a[SECT_POS +: SECT_W] = s;
    a[ADDR_ONE_POS] = a1;
    a[ADDR_SIX_POS] = a6;
    a[ADDR_ZERO_POS] = 1'b0;
    return a;
  endfunction

  function automatic fsp_pins_t idle_pins();
    fsp_pins_t p;
    p = '0;
    p.ce_n = 1'b1;
    p.oe_n = 1'b1;
    p.we_n = 1'b1;
    return p;
  endfunction

  fsp_pulse #(.CNT_W(CNT_W)) u_timer (
    .clk_in(MCLK_IN),
    .rst_in(RESET_IN),
    .start_in(t_start),
    .len_in(t_len),
    .busy_out(t_busy),
    .done_out(t_done)
  );

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    sect_d = sect_q;
    pins_d = pins_q;
    dq_d = dq_q;
    dq_oe_n_d = dq_oe_n_q;
    stat_d = stat_q;
    prot_d = prot_q;
    cmd_d = cmd_q;
    t_start = 1'b0;
    t_len = CNT_W'(SETUP_CYC);
    unique case (st_q)
      S_IDLE: begin
        if (REQ_VALID_IN) begin
          op_d = REQ_OP_IN;
          sect_d = REQ_SECTOR_IN;
          t_start = 1'b1;
          pins_d = idle_pins();
          cmd_d = 2'd0;
          unique case (REQ_OP_IN)
            OP_PROTECT: begin
              pins_d.address_bit_nine_hv = 1'b1;
              pins_d.oe_hv = 1'b1;
              pins_d.ce_n = 1'b0;
              pins_d.addr = sect_addr(REQ_SECTOR_IN, 1'b1, 1'b0);
              st_d = S_SETUP;
            end
            OP_UNPROTECT: begin
              // Protecting every sector first is left to the caller
              pins_d.address_bit_nine_hv = 1'b1;
              pins_d.oe_hv = 1'b1;
              pins_d.ce_n = 1'b0;
              pins_d.addr = sect_addr('0, 1'b1, 1'b1);
              st_d = S_SETUP;
            end
            OP_VERIFY: begin
              pins_d.address_bit_nine_hv = 1'b1;
              pins_d.ce_n = 1'b0;
              pins_d.addr = sect_addr(REQ_SECTOR_IN, 1'b1,
                                      1'b0);
              st_d = S_RDSET;
            end
            default: begin
              st_d = S_CMD;
            end
          endcase
        end
      end
      S_SETUP: begin
        if (!t_busy) begin
          pins_d.we_n = 1'b0;
          t_start = 1'b1;
          t_len = (op_q == OP_UNPROTECT) ? CNT_W'(UNPROT_CYC)
                                         : CNT_W'(PROT_CYC);
          st_d = S_PULSE;
        end
      end
      S_PULSE: begin
        if (t_done) begin
          pins_d.we_n = 1'b1;
          t_start = 1'b1;
          st_d = S_HOLD;
        end
      end
      S_HOLD: begin
        if (!t_busy) begin
          pins_d = idle_pins();
          st_d = S_DONE;
        end
      end
      S_RDSET: begin
        if (!t_busy) begin
          pins_d.oe_n = 1'b0;
          t_start = 1'b1;
          t_len = CNT_W'(READ_CYC);
          st_d = S_RDWAIT;
        end
      end
      S_RDWAIT: begin
        if (t_done) begin
          stat_d = DQ_IN;
          prot_d = DQ_IN[0];
          pins_d = idle_pins();
          st_d = (op_q == OP_SYS_STATUS) ? S_RST : S_DONE;
        end
      end
      S_CMD: begin
        // Unlock, unlock, identification-read command cycles
        pins_d.ce_n = 1'b0;
        pins_d.we_n = 1'b0;
        dq_oe_n_d = 1'b0;
        unique case (cmd_q)
          2'd0: begin
            pins_d.addr = ADDR_UNLOCK1;
            dq_d = CMD_UNLOCK1;
          end
          2'd1: begin
            pins_d.addr = ADDR_UNLOCK2;
            dq_d = CMD_UNLOCK2;
          end
          default: begin
            pins_d.addr = ADDR_UNLOCK1;
            dq_d = CMD_ID_READ;
          end
        endcase
        t_start = 1'b1;
        st_d = S_CMDW;
      end
      S_CMDW: begin
        if (!t_busy) begin
          pins_d.we_n = 1'b1;
          t_start = 1'b1;
          st_d = S_CMDGAP;
        end
      end
      S_CMDGAP: begin
        if (!t_busy) begin
          dq_oe_n_d = 1'b1;
          if (cmd_q == 2'd2) begin
            pins_d.addr = sect_addr(sect_q, 1'b1, 1'b0);
            t_start = 1'b1;
            st_d = S_RDSET;
          end else begin
            cmd_d = cmd_q + 2'd1;
            st_d = S_CMD;
          end
        end
      end
      S_RST: begin
        // Leave identification mode so array reads resume
        pins_d.ce_n = 1'b0;
        pins_d.we_n = 1'b0;
        pins_d.addr = '0;
        dq_d = CMD_RESET;
        dq_oe_n_d = 1'b0;
        t_start = 1'b1;
        st_d = S_RSTW;
      end
      S_RSTW: begin
        if (!t_busy) begin
          pins_d = idle_pins();
          dq_oe_n_d = 1'b1;
          st_d = S_DONE;
        end
      end
      S_DONE: begin
        st_d = S_IDLE;
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      st_q <= S_IDLE;
      op_q <= OP_PROTECT;
      sect_q <= '0;
      pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      dq_q <= '0;
      dq_oe_n_q <= 1'b1;
      stat_q <= '0;
      prot_q <= 1'b0;
      cmd_q <= '0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      sect_q <= sect_d;
      pins_q <= pins_d;
      dq_q <= dq_d;
      dq_oe_n_q <= dq_oe_n_d;
      stat_q <= stat_d;
      prot_q <= prot_d;
      cmd_q <= cmd_d;
    end
  end

  assign REQ_READY_OUT = (st_q == S_IDLE);
  assign DONE_OUT = (st_q == S_DONE);
  assign PROTECTED_OUT = prot_q;
  assign STATUS_DATA_OUT = stat_q;
  assign PINS_OUT = pins_q;
  assign DQ_OUT = dq_q;
  assign DQ_OE_N_OUT = dq_oe_n_q;
endmodule

// File: verif/fsp_host_checker.sv
`timescale 1ns/1ps
module fsp_chk
  import fsp_pkg::*;
(
  input wire logic MCLK_IN, // Clock
  input wire logic RESET_IN, // Reset
  input wire logic REQ_VALID_IN, // Request
  input wire logic REQ_READY_OUT, // Idle
  input wire logic DONE_OUT, // Done pulse
  input wire logic PROTECTED_OUT, // Status bit
  input wire logic [fsp_pkg::DATA_W-1:0] STATUS_DATA_OUT, // Read byte
  input wire fsp_pkg::fsp_pins_t PINS_OUT, // Flash pins
  input wire logic DQ_OE_N_OUT // Data drive
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);
  chk_we_with_ce: assert property (!PINS_OUT.we_n |-> !PINS_OUT.ce_n)
    else $error("write strobe without chip select");
  chk_hv_pair: assert property (!PINS_OUT.we_n && PINS_OUT.oe_hv |->
    PINS_OUT.address_bit_nine_hv)
    else $error("raised pulse lacks address raise");
  chk_hv_len: assert property ($fell(PINS_OUT.we_n) && PINS_OUT.oe_hv
    |-> !PINS_OUT.we_n [*8]) else $error("raised write pulse too short");
  chk_verify_pins: assert property (!PINS_OUT.oe_n &&
    PINS_OUT.address_bit_nine_hv |-> PINS_OUT.addr[1] && !PINS_OUT.addr[0] &&
    !PINS_OUT.addr[6] && PINS_OUT.we_n && !PINS_OUT.oe_hv)
    else $error("bad verify pins");
  chk_sys_read: assert property (!PINS_OUT.oe_n &&
    !PINS_OUT.address_bit_nine_hv |-> PINS_OUT.addr[1] && DQ_OE_N_OUT)
    else $error("bad status read");
  chk_cmd_drive: assert property (!PINS_OUT.we_n && !PINS_OUT.oe_hv |->
    !DQ_OE_N_OUT && PINS_OUT.oe_n) else $error("command write not driven");
  chk_status_bit: assert property (DONE_OUT |->
    PROTECTED_OUT == STATUS_DATA_OUT[0]) else $error("status bit mismatch");
  chk_take_busy: assert property (REQ_VALID_IN && REQ_READY_OUT |=>
    !REQ_READY_OUT ##1 !DONE_OUT) else $error("request not taken");
endmodule
bind fsp_host fsp_chk i_fsp_chk (.MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN),
  .REQ_VALID_IN(REQ_VALID_IN), .REQ_READY_OUT(REQ_READY_OUT),
  .DONE_OUT(DONE_OUT), .PROTECTED_OUT(PROTECTED_OUT),
  .STATUS_DATA_OUT(STATUS_DATA_OUT), .PINS_OUT(PINS_OUT),
  .DQ_OE_N_OUT(DQ_OE_N_OUT));

// File: verif/fsp_flash_model.sv
`timescale 1ns/1ps
module fsp_flash_model
  import fsp_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary value
) (
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Power-up clear
  input wire fsp_pkg::fsp_pins_t pins_in, // Pins from host
  input wire logic [fsp_pkg::DATA_W-1:0] dq_in, // Host data
  output logic [fsp_pkg::DATA_W-1:0] dq_out // Device data
);
  logic [2**SECT_W-1:0] prot_q; // One lock bit per sector
  logic [1:0] seq_q;
  logic id_q, we_q, ce_q, rd;
  logic [DATA_W-1:0] last_q;
  logic [SECT_W-1:0] sec;
  assign sec = pins_in.addr[SECT_POS +: SECT_W];
  assign rd = !pins_in.ce_n && !pins_in.oe_n && pins_in.we_n &&
    (pins_in.address_bit_nine_hv || id_q);
  always_comb begin
    // Released bus shows the inverse so stale data never matches
    if (!rd) dq_out = ~last_q;
    else if (pins_in.addr[ADDR_ONE_POS])
      dq_out = {7'h00, prot_q[sec]};
    else dq_out = ID_CODE;
  end
  // Command addresses are not decoded; only the data sequence counts
  always_ff @(posedge clk_in) begin
    we_q <= pins_in.we_n;
    ce_q <= pins_in.ce_n;
    if (rd) last_q <= dq_out;
    if (rst_in) begin
      prot_q <= '0;
      seq_q <= 2'h0;
      id_q <= 1'b0;
      we_q <= 1'b1;
      ce_q <= 1'b1;
      last_q <= 8'h00;
    end else if (pins_in.we_n && !we_q && !ce_q) begin
      // Chip select may rise with write enable; the write still counts
      if (pins_in.address_bit_nine_hv && pins_in.oe_hv) begin
        if (pins_in.addr[ADDR_SIX_POS]) prot_q <= '0;
        else prot_q[sec] <= 1'b1;
      end else if (dq_in == CMD_RESET) begin
        id_q <= 1'b0;
        seq_q <= 2'h0;
      end else if (seq_q == 2'h2 && dq_in == CMD_ID_READ) begin
        id_q <= 1'b1;
        seq_q <= 2'h0;
      end else if (seq_q == 2'h1 && dq_in == CMD_UNLOCK2) seq_q <= 2'h2;
      else seq_q <= (dq_in == CMD_UNLOCK1) ? 2'h1 : 2'h0;
    end
  end
endmodule

// File: verif/flash_sector_protect_control_tb.sv
`timescale 1ns/1ps
module flash_sector_protect_control_tb;
  import fsp_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  fsp_op_t req_op = OP_VERIFY;
  logic [SECT_W-1:0] req_sector = 4'h0;
  logic ready, done, prot, dq_oe_n;
  logic [DATA_W-1:0] status, dq_host, dq_dev;
  fsp_pins_t pins;
  int err_total = 0;
  int tests_run = 0;
  always #10 mclk = ~mclk;
  fsp_host #(.PROT_CYC(10), .UNPROT_CYC(20)) i_fsp_host (.MCLK_IN(mclk),
    .RESET_IN(rst), .REQ_VALID_IN(req_valid), .REQ_READY_OUT(ready),
    .REQ_OP_IN(req_op), .REQ_SECTOR_IN(req_sector), .DONE_OUT(done),
    .PROTECTED_OUT(prot), .STATUS_DATA_OUT(status), .PINS_OUT(pins),
    .DQ_OUT(dq_host), .DQ_OE_N_OUT(dq_oe_n), .DQ_IN(dq_dev));
  fsp_flash_model i_fsp_flash_model (.clk_in(mclk), .rst_in(rst),
    .pins_in(pins), .dq_in(dq_host), .dq_out(dq_dev));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [DATA_W-1:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Runs one operation; the status bit must then read exp_bit
  task automatic run(input fsp_op_t op, input logic [SECT_W-1:0] s,
    input logic exp_bit, output logic [DATA_W-1:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op <= op;
    req_sector <= s;
    @(negedge mclk);
    check({7'h00, ready}, 8'h01);
    @(posedge mclk);
    req_valid <= 1'b0;
    while (done !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > 2000) begin
        err_total++;
        report_and_stop();
      end
    end
    rd = status;
    check({7'h00, prot}, {7'h00, exp_bit});
  endtask
  task automatic sc_fresh();
    logic [DATA_W-1:0] d;
    run(OP_VERIFY, 4'h3, 1'b0, d);
    check(d, 8'h00);
    run(OP_SYS_STATUS, 4'h3, 1'b0, d);
    check(d, 8'h00);
  endtask
  task automatic sc_protect();
    logic [DATA_W-1:0] d;
    run(OP_PROTECT, 4'h3, 1'b0, d);
    run(OP_VERIFY, 4'h3, 1'b1, d);
    check(d, 8'h01);
    run(OP_VERIFY, 4'h4, 1'b0, d);
    check(d, 8'h00);
    run(OP_SYS_STATUS, 4'h3, 1'b1, d);
    check(d, 8'h01);
    run(OP_SYS_STATUS, 4'h4, 1'b0, d);
    check(d, 8'h00);
  endtask
  task automatic sc_unprotect();
    logic [DATA_W-1:0] d;
    for (int i = 0; i < 16; i++) begin
      run(OP_PROTECT, SECT_W'(i), 1'b0, d);
    end
    run(OP_VERIFY, 4'hF, 1'b1, d);
    check(d, 8'h01);
    run(OP_VERIFY, 4'h0, 1'b1, d);
    check(d, 8'h01);
    run(OP_UNPROTECT, 4'h0, 1'b1, d);
    run(OP_VERIFY, 4'hF, 1'b0, d);
    check(d, 8'h00);
    run(OP_SYS_STATUS, 4'h3, 1'b0, d);
    check(d, 8'h00);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    sc_fresh();
    sc_protect();
    sc_unprotect();
    report_and_stop();
  end
endmodule
